// *** core/bfsr_consts.vh ***
// Purpose: Constants for the bit field set and clear execution unit.
// Assumes: One CPU cycle clock, word memory of 16-bit words.
// Notes: Included by core/bfsr_unit.v only.
// Function
// - Decode multi-bit set at code 530 and multi-bit clear at 531.
// - Decode single-bit set at code 532 and single-bit clear at 533.
// - Multi-bit ops raise error flag when start bit exceeds 15, else clear it.
// - Multi-bit set turns on the run upward from start bit, across words.
// - Multi-bit clear turns off the run upward from start bit, across words.
// - A run length of zero alters no memory bit.
// - Single-bit set turns the bit on only while condition is on.
// - Single-bit clear turns the bit off only while condition is on.
// - Single-bit ops raise error flag when bit number exceeds 15, else clear it.
// - An interlocked or jumped section leaves the addressed bit unchanged.
// - Immediate variants push a changed output word to the pins at once.
// - Single-bit ops reach any word area, data memory included.
`ifndef BFSR_CONSTS_VH
`define BFSR_CONSTS_VH

// ==========================================
// Function codes
`define BFSR_FC_MULTI_SET 10'h212
`define BFSR_FC_MULTI_CLR 10'h213
`define BFSR_FC_SINGLE_SET 10'h214
`define BFSR_FC_SINGLE_CLR 10'h215

// ==========================================
// Bit numbering
`define BFSR_MAX_BIT 16'h000f
`define BFSR_WORD_BITS 5'h10

// ==========================================
// Register byte offsets
`define BFSR_REG_CTRL 8'h00
`define BFSR_REG_STATUS 8'h04
`define BFSR_REG_MEM_ADDR 8'h08
`define BFSR_REG_MEM_DATA 8'h0c
`define BFSR_REG_OUT_IMAGE 8'h10

// ==========================================
// Fields, reset values, responses
`define BFSR_CTRL_ENABLE 0
`define BFSR_STAT_BUSY 0
`define BFSR_STAT_ERROR 1
`define BFSR_CTRL_RESET 1'b1
`define BFSR_OUT_WORD 8'h64
`define BFSR_RESP_OKAY 2'h0
`define BFSR_RESP_SLVERR 2'h2

`endif

// *** core/bfsr_unit.v ***
// Purpose: Executes multi-bit and single-bit set and clear instructions on word memory.
// Assumes: Sequencer on the same clock; AXI4-Lite master for software access.
// Notes: Memory is one flat array covering every word area.
`timescale 1ns/1ps
`include "bfsr_consts.vh"

module bfsr_unit #(
   parameter MEM_WORDS = 256,
   parameter AW = 8,
   parameter OUT_WORD = `BFSR_OUT_WORD
) (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Instruction request from the sequencer
   input wire req_valid_i,
   input wire [9:0] req_func_i,
   input wire req_cond_i,
   input wire req_cond_prev_i,
   input wire req_diff_i,
   input wire req_imm_i,
   input wire req_blocked_i,
   input wire [AW-1:0] req_word_i,
   input wire [15:0] req_bit_i,
   input wire [15:0] req_len_i,
   input wire scan_end_i,
   // Instruction answer
   output reg ready_o,
   output reg done_o,
   output reg operand_error_flag_o,
   output reg [15:0] phys_out_o,
   // AXI4-Lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // ==========================================
   // Mask of bits pos upward, at most rem of them
   function [15:0] run_mask;
      input [3:0] pos;
      input [15:0] rem;
      integer i;
      begin
         run_mask = 16'h0000;
         for (i = 0; i < 16; i = i + 1) begin
            if ((i >= pos) && ((i - pos) < rem)) begin
               run_mask[i] = 1'b1;
            end
         end
      end
   endfunction

   reg [15:0] mem [0:MEM_WORDS-1];
   reg state;
   reg op_set;
   reg op_imm;
   reg [AW-1:0] cur_word;
   reg [3:0] cur_pos;
   reg [15:0] remain;
   reg unit_enable;
   reg [AW-1:0] mem_addr;
   reg aw_got;
   reg w_got;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   // ==========================================
   // Request decode
   wire is_multi = (req_func_i == `BFSR_FC_MULTI_SET) ||
      (req_func_i == `BFSR_FC_MULTI_CLR);
   wire is_single = (req_func_i == `BFSR_FC_SINGLE_SET) ||
      (req_func_i == `BFSR_FC_SINGLE_CLR);
   wire is_set = (req_func_i == `BFSR_FC_MULTI_SET) || (req_func_i == `BFSR_FC_SINGLE_SET);
   wire cond_ok = req_diff_i ? (req_cond_i && !req_cond_prev_i) : req_cond_i;
   // Blocked section executes nothing and keeps the bit
   wire exec = unit_enable && !req_blocked_i && (is_multi || is_single) && cond_ok;
   wire bit_bad = (req_bit_i > `BFSR_MAX_BIT);
   wire run_len_zero = is_multi && (req_len_i == 16'h0000);
   wire act = exec && !bit_bad && !run_len_zero;
   wire take = req_valid_i && ready_o;

   // ==========================================
   // Word step of the running operation
   wire [4:0] room = `BFSR_WORD_BITS - {1'b0, cur_pos};
   wire [15:0] mask = run_mask(cur_pos, remain);
   wire last_word = (remain <= {11'h000, room});
   wire [15:0] old_word = mem[cur_word];
   // Set ors the run in, clear masks it out; other bits are kept
   wire [15:0] new_word = op_set ? (old_word | mask) : (old_word & ~mask);

   // ==========================================
   // Software write decode
   wire wr_fire = aw_got && w_got && !s_axi_bvalid;
   wire wr_mem = (aw_addr == `BFSR_REG_MEM_DATA);
   // Memory writes from software wait while an operation runs
   wire wr_go = wr_fire && !(wr_mem && (state == ST_RUN));
   wire wr_map = (aw_addr == `BFSR_REG_CTRL) || (aw_addr == `BFSR_REG_MEM_ADDR) || wr_mem;
   wire [15:0] wr_word = {w_strb[1] ? w_data[15:8] : mem[mem_addr][15:8],
      w_strb[0] ? w_data[7:0] : mem[mem_addr][7:0]};

   // ==========================================
   // Execution sequencing
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         ready_o <= 1'b1;
         done_o <= 1'b0;
         operand_error_flag_o <= 1'b0;
         op_set <= 1'b0;
         op_imm <= 1'b0;
         cur_word <= {AW{1'b0}};
         cur_pos <= 4'h0;
         remain <= 16'h0000;
      end else begin
         done_o <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (take) begin
                  if (exec) begin
                     operand_error_flag_o <= bit_bad;
                  end
                  op_set <= is_set;
                  op_imm <= req_imm_i;
                  cur_word <= req_word_i;
                  cur_pos <= req_bit_i[3:0];
                  // Single-bit ops reach any word of the flat memory
                  remain <= is_single ? 16'h0001 : req_len_i;
                  if (act) begin
                     ready_o <= 1'b0;
                     state <= ST_RUN;
                  end else begin
                     done_o <= 1'b1;
                  end
               end
            end
            ST_RUN: begin
               if (last_word) begin
                  remain <= 16'h0000;
                  done_o <= 1'b1;
                  ready_o <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  // Continue into the next word from its bit 0
                  remain <= remain - {11'h000, room};
                  cur_pos <= 4'h0;
                  cur_word <= cur_word + {{(AW-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               state <= ST_IDLE;
               ready_o <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================
   // Memory array
   always @(posedge clock_i) begin
      if (state == ST_RUN) begin
         mem[cur_word] <= new_word;
      end else if (wr_go && wr_mem) begin
         mem[mem_addr] <= wr_word;
      end
   end

   // ==========================================
   // Physical output refresh
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phys_out_o <= 16'h0000;
      end else if ((state == ST_RUN) && op_imm && (cur_word == OUT_WORD)) begin
         phys_out_o <= new_word;
      end else if (scan_end_i) begin
         phys_out_o <= mem[OUT_WORD];
      end
   end

   // ==========================================
   // AXI4-Lite write channel
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `BFSR_RESP_OKAY;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         unit_enable <= `BFSR_CTRL_RESET;
         mem_addr <= {AW{1'b0}};
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? `BFSR_RESP_OKAY : `BFSR_RESP_SLVERR;
            if ((aw_addr == `BFSR_REG_CTRL) && w_strb[0]) begin
               unit_enable <= w_data[`BFSR_CTRL_ENABLE];
            end
            if ((aw_addr == `BFSR_REG_MEM_ADDR) && w_strb[0]) begin
               mem_addr <= w_data[AW-1:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ==========================================
   // AXI4-Lite read channel
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `BFSR_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `BFSR_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (s_axi_araddr)
               `BFSR_REG_CTRL: begin
                  s_axi_rdata[`BFSR_CTRL_ENABLE] <= unit_enable;
               end
               `BFSR_REG_STATUS: begin
                  s_axi_rdata[`BFSR_STAT_BUSY] <= (state == ST_RUN);
                  s_axi_rdata[`BFSR_STAT_ERROR] <= operand_error_flag_o;
               end
               `BFSR_REG_MEM_ADDR: begin
                  s_axi_rdata[AW-1:0] <= mem_addr;
               end
               `BFSR_REG_MEM_DATA: begin
                  s_axi_rdata[15:0] <= mem[mem_addr];
               end
               `BFSR_REG_OUT_IMAGE: begin
                  s_axi_rdata[15:0] <= phys_out_o;
               end
               default: begin
                  s_axi_rresp <= `BFSR_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // bfsr_unit

// *** tb/bfsr_seq_model.sv ***
// Purpose: Instruction sequencer model driving the unit's request port.
// Assumes: Request is taken at an edge with ready high.
// Notes: Released fields show the inverse of the last request.
`timescale 1ns/1ps
module bfsr_seq_model (
   // Clock and answer
   input wire clock_i,
   input wire ready_i,
   input wire done_i,
   // Request
   output logic valid_o = 1'b0,
   output logic [9:0] func_o = 10'h000,
   output logic cond_o = 1'b0,
   output logic prev_o = 1'b0,
   output logic diff_o = 1'b0,
   output logic imm_o = 1'b0,
   output logic blk_o = 1'b0,
   output logic [7:0] word_o = 8'h00,
   output logic [15:0] bit_o = 16'h0000,
   output logic [15:0] len_o = 16'h0000
);
   // Only word memory is targeted, never timer or counter bits
   task issue(input logic [9:0] f, input logic c, p, df, im, bl,
      input logic [7:0] w, input logic [15:0] b, l);
      begin
         {func_o, cond_o, prev_o, diff_o, imm_o, blk_o, word_o, bit_o, len_o} <= {f, c, p, df, im, bl, w, b, l};
         valid_o <= 1'b1;
         do @(posedge clock_i); while (!ready_i);
         valid_o <= 1'b0;
         {func_o, cond_o, prev_o, diff_o, imm_o, blk_o, word_o, bit_o, len_o} <= ~{f, c, p, df, im, bl, w, b, l};
         do @(posedge clock_i); while (!done_i);
      end
   endtask
endmodule // bfsr_seq_model

// *** tb/bfsr_unit_properties.sv ***
// Purpose: Port-level checks of the bit field set and clear unit.
// Assumes: One clock domain, active-low asynchronous reset.
// Notes: Bound to bfsr_unit from the testbench top file.
`timescale 1ns/1ps
module bfsr_unit_checker (
   // Clock and reset
   input wire clock_i,
   input wire rstn_i,
   // Request
   input wire req_valid_i,
   input wire [9:0] req_func_i,
   input wire req_cond_i,
   input wire req_cond_prev_i,
   input wire req_diff_i,
   input wire req_blocked_i,
   input wire [15:0] req_bit_i,
   input wire [15:0] req_len_i,
   // Answer
   input wire ready_o,
   input wire done_o,
   input wire operand_error_flag_o
);
   wire take = req_valid_i && ready_o;
   wire bad = req_bit_i > 16'h000f;
   wire known = req_func_i >= 10'h212 && req_func_i <= 10'h215;
   wire multi = req_func_i <= 10'h213;
   wire run = take && known && req_cond_i && !req_blocked_i && !(req_diff_i && req_cond_prev_i);
   wire [16:0] span = {1'b0, req_bit_i} + {1'b0, req_len_i};
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   sequence s_done; done_o && ready_o; endsequence
   sequence s_busy_one; !ready_o ##1 s_done; endsequence
   a_err_on: assert property (run && bad |=> operand_error_flag_o)
      else $error("flag low after bad bit number");
   a_err_off: assert property (run && !bad |=> !operand_error_flag_o)
      else $error("flag high after good bit number");
   a_block_keep: assert property (take && req_blocked_i |=> done_o && $stable(operand_error_flag_o))
      else $error("blocked request acted");
   a_cond_off: assert property (take && !req_cond_i |=> done_o && $stable(operand_error_flag_o))
      else $error("request with condition off acted");
   a_diff_edge: assert property (take && req_diff_i && req_cond_prev_i |=> done_o)
      else $error("differentiated request acted without edge");
   a_code_decode: assert property (take && !known |=> s_done and $stable(operand_error_flag_o))
      else $error("unknown code acted");
   a_len_zero: assert property (run && multi && !bad && req_len_i == 16'h0000 |=> done_o)
      else $error("zero length run wrote memory");
   a_single_time: assert property (run && !multi && !bad |=> s_busy_one)
      else $error("single bit op timing wrong");
   a_multi_one: assert property (run && multi && !bad && req_len_i != 16'h0000 && span <= 17'h10 |=> s_busy_one)
      else $error("one word run timing wrong");
   a_multi_two: assert property (run && multi && !bad && span > 17'h10 && span <= 17'h20 |=> !ready_o [*2] ##1 s_done)
      else $error("two word run timing wrong");
endmodule // bfsr_unit_checker

// *** tb/bit_field_set_reset_unit_tb.sv ***
// Purpose: Self-checking bench for the bit field set and clear unit.
// Assumes: Memory reached through MEM_ADDR and MEM_DATA registers.
// Notes: Words 5 and 6 hold the table cases, word 0x64 the outputs.
`timescale 1ns/1ps
module bit_field_set_reset_unit_tb;
   typedef struct {logic [9:0] f; logic c, p, d, bl; logic [15:0] b, l, pre, e0, e1; logic ef;} bfsr_row_t;
   logic clock_i = 1'b0, rstn_i = 1'b0, scan = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, rv, rdy, dn, flag, cnd, prv, dif, imm, blk;
   logic [1:0] bresp, rresp, rs;
   logic [9:0] fn;
   logic [7:0] wd;
   logic [15:0] bt, ln, phys;
   int bad_count = 0, n_checks = 0, cyc = 0;
   bfsr_row_t rows[14] = '{
      '{10'h212,1,0,0,0,12,6,16'h0000,16'hf000,16'h0003,0}, '{10'h213,1,0,0,0,3,20,16'hffff,16'h0007,16'hff80,0},
      '{10'h212,1,0,0,0,4,0,0,0,0,0}, '{10'h212,1,0,0,0,16,2,0,0,0,1}, '{10'h214,1,0,0,1,15,0,0,0,0,1},
      '{10'h214,1,0,0,0,15,0,0,16'h8000,0,0}, '{10'h215,1,0,0,0,0,0,16'hffff,16'hfffe,16'hffff,0},
      '{10'h215,0,0,0,0,1,0,16'hffff,16'hffff,16'hffff,0}, '{10'h215,1,0,0,0,16,0,16'hffff,16'hffff,16'hffff,1},
      '{10'h213,0,0,0,0,0,4,16'hffff,16'hffff,16'hffff,1}, '{10'h211,1,0,0,0,0,4,0,0,0,1},
      '{10'h212,1,1,1,0,0,16,0,0,0,1}, '{10'h212,1,0,1,0,0,16,0,16'hffff,0,0},
      '{10'h213,1,0,1,0,15,2,16'hffff,16'h7fff,16'hfffe,0}};
   bfsr_seq_model seq (.clock_i(clock_i), .ready_i(rdy), .done_i(dn), .valid_o(rv), .func_o(fn),
      .cond_o(cnd), .prev_o(prv), .diff_o(dif), .imm_o(imm), .blk_o(blk), .word_o(wd), .bit_o(bt), .len_o(ln));
   bfsr_unit uut (.clock_i(clock_i), .rstn_i(rstn_i), .req_valid_i(rv), .req_func_i(fn), .req_cond_i(cnd),
      .req_cond_prev_i(prv), .req_diff_i(dif), .req_imm_i(imm), .req_blocked_i(blk), .req_word_i(wd),
      .req_bit_i(bt), .req_len_i(ln), .scan_end_i(scan), .ready_o(rdy), .done_o(dn),
      .operand_error_flag_o(flag), .phys_out_o(phys), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   task stop_test;
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         $display("BAD %s exp %h got %h", n, e, s);
         bad_count++;
      end
   endtask
   task axw(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk("write response", bresp, 32'h00000000);
      bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock_i);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task mem(input logic [7:0] w, input logic [15:0] d, input bit wr);
      axw(8'h08, {24'h0, w});
      if (wr) axw(8'h0c, {16'h0, d});
      else axr(8'h0c);
   endtask
   task scan_pulse;
      scan <= 1'b1;
      @(posedge clock_i);
      scan <= 1'b0;
      @(posedge clock_i);
   endtask
   initial forever #12.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      foreach (rows[i]) begin
         mem(8'h05, rows[i].pre, 1);
         mem(8'h06, rows[i].pre, 1);
         seq.issue(rows[i].f, rows[i].c, rows[i].p, rows[i].d, 1'b0, rows[i].bl, 8'h05, rows[i].b, rows[i].l);
         chk("error flag", flag, rows[i].ef);
         mem(8'h05, 0, 0);
         chk("first word", v[15:0], rows[i].e0);
         mem(8'h06, 0, 0);
         chk("next word", v[15:0], rows[i].e1);
      end
      mem(8'h64, 16'h0001, 1);
      scan_pulse;
      chk("outputs loaded", phys, 32'h00000001);
      seq.issue(10'h214, 1, 0, 0, 1'b1, 0, 8'h64, 2, 0);
      chk("immediate output", phys, 32'h00000005);
      seq.issue(10'h214, 1, 0, 0, 1'b0, 0, 8'h64, 3, 0);
      chk("deferred output", phys, 32'h00000005);
      scan_pulse;
      chk("scan output", phys, 32'h0000000d);
      axr(8'h20);
      chk("unmapped response", rs, 2);
      seq.issue(10'h215, 1, 0, 0, 1'b0, 0, 8'h05, 16, 0);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk("flag at reset", flag, 0);
      chk("ready at reset", rdy, 1);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      stop_test;
   end
endmodule // bit_field_set_reset_unit_tb
bind bfsr_unit bfsr_unit_checker props (.clock_i(clock_i), .rstn_i(rstn_i), .req_valid_i(req_valid_i),
   .req_func_i(req_func_i), .req_cond_i(req_cond_i), .req_cond_prev_i(req_cond_prev_i),
   .req_diff_i(req_diff_i), .req_blocked_i(req_blocked_i), .req_bit_i(req_bit_i),
   .req_len_i(req_len_i), .ready_o(ready_o), .done_o(done_o),
   .operand_error_flag_o(operand_error_flag_o));
